// [design/spri_defines.svh]
`ifndef SPRI_DEFINES_SVH
`define SPRI_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define SPRI_ADDR_DATA 3'h0
`define SPRI_ADDR_STATUS_A 3'h1
`define SPRI_ADDR_CONTROL_B 3'h2
`define SPRI_ADDR_BAUD_LOW 3'h3
`define SPRI_ADDR_SHARED 3'h4
// ****************************************
// fields and reset values
// ****************************************
`define SPRI_SEL_BIT 7
`define SPRI_TXC_BIT 6
`define SPRI_RESET_CONTROL_C 8'h80
`define SPRI_RESET_STATUS_A 8'h20
`define SPRI_WORD_FE 9
`define SPRI_WORD_PE 10
// ****************************************
// timing
// ****************************************
`define SPRI_OVERSAMPLE_NORMAL 4'hf
`define SPRI_OVERSAMPLE_DOUBLE 4'h7
`define SPRI_OVERSAMPLE_SYNC 4'h1
`endif

// [design/spri_pkg.sv]
package spri_pkg;
  // receiver sequencing
  typedef enum logic [1:0] {
    SPRI_RX_IDLE = 2'b00,
    SPRI_RX_BUSY = 2'b01
  } spri_rx_state_t;
endpackage

// [design/spri_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "spri_defines.svh"

module spri_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } spri_fifo_state_t;
  spri_fifo_state_t s_q, s_d;
  logic push, pop;

  if (DEPTH < 2) $error("spri_fifo needs at least two entries");

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // handshake terms
  assign in_ready = (s_q.cnt != CW'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = wrap_inc(s_q.wr);
    end
    if (pop)
      s_d.rd = wrap_inc(s_q.rd);
    if (push && !pop)
      s_d.cnt = s_q.cnt + CW'(1);
    else if (pop && !push)
      s_d.cnt = s_q.cnt - CW'(1);
    if (flush)
    begin
      s_d.wr = '0;
      s_d.rd = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

module spri_top #(
  parameter int RX_DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // interrupt side
  input wire logic global_irq_enable,
  input wire logic tx_complete_ack,
  output logic irq_rx_complete,
  output logic irq_tx_complete,
  output logic irq_tx_empty,
  // serial pins
  input wire logic rxd,
  output logic rx_pin_owned,
  output logic txd,
  output logic txd_oe
);
  typedef struct packed {
    logic tx_complete_flag;
    logic double_speed;
    logic multiprocessor_filter;
    logic overrun_flag;
    logic rx_complete_irq_enable;
    logic tx_complete_irq_enable;
    logic tx_empty_irq_enable;
    logic receiver_enable;
    logic transmitter_enable;
    logic char_size_msb;
    logic tx_ninth_bit;
    logic [6:0] control_c;
    logic [11:0] baud_divisor;
    logic shared_rd;
    logic [8:0] transmit_buffer;
    logic tx_full;
    logic tx_active;
    logic tx_busy;
    logic [12:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic [11:0] prescale;
    spri_pkg::spri_rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_idx;
    logic [11:0] rx_shift;
    logic rx_pend;
    logic [10:0] rx_word;
    logic [7:0] rdata;
    logic irq_rx;
    logic irq_tx;
    logic irq_empty;
    logic txd;
  } spri_state_t;
  spri_state_t s_q, s_d;

  if (RX_DEPTH < 2) $error("spri_top needs a receive fifo of two or more");

  // control C fields
  logic sync_mode_select;
  logic parity_enable_bit;
  logic parity_odd;
  logic stop_two;
  logic [1:0] char_size_low_bits;
  logic [3:0] nbits;
  logic [3:0] div_last;
  logic tick;
  assign sync_mode_select = s_q.control_c[6];
  assign parity_enable_bit = s_q.control_c[5];
  assign parity_odd = s_q.control_c[4];
  assign stop_two = s_q.control_c[3];
  assign char_size_low_bits = s_q.control_c[2:1];
  assign nbits = char_bits({s_q.char_size_msb, char_size_low_bits});
  assign tick = (s_q.prescale == 12'h000);

  // fifo link
  logic rx_push, rx_ready, rx_valid, rx_pop;
  logic [10:0] rx_head, rx_new;
  logic [11:0] rx_sh_now;
  logic rd_data, rd_shared, wr_data, wr_shared, frame_done, start_seen;

  function automatic logic [3:0] char_bits(input logic [2:0] code);
    unique case (code)
      3'b000: char_bits = 4'h5;
      3'b001: char_bits = 4'h6;
      3'b010: char_bits = 4'h7;
      3'b111: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  // build start, data, parity and stop bits, lsb first
  function automatic logic [12:0] tx_frame(input logic [8:0] d, input logic [3:0] n,
                                           input logic pen, input logic odd);
    logic [12:0] f;
    logic p;
    f = 13'h1ffe;
    p = odd;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < n)
      begin
        f[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pen)
      f[n+4'h1] = p;
    tx_frame = f;
  endfunction

  // extract {pe, fe, ninth, data} from sampled bits
  function automatic logic [10:0] rx_decode(input logic [11:0] sh, input logic [3:0] n,
                                            input logic pen, input logic odd);
    logic [8:0] d;
    logic p;
    d = 9'h000;
    p = odd;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < n)
      begin
        d[i] = sh[i+1];
        p = p ^ sh[i+1];
      end
    end
    rx_decode = {pen && (p != sh[n+4'h1]), !sh[n+4'h1+4'(pen)], d};
  endfunction

  assign rd_data = io_rd && (io_addr == `SPRI_ADDR_DATA);
  assign rd_shared = io_rd && (io_addr == `SPRI_ADDR_SHARED);
  assign wr_data = io_wr && (io_addr == `SPRI_ADDR_DATA);
  assign wr_shared = io_wr && (io_addr == `SPRI_ADDR_SHARED);
  assign rx_pop = rd_data;
  // stop bit is sampled in the frame_done cycle, so fold it in before decoding
  always_comb
  begin
    rx_sh_now = s_q.rx_shift;
    rx_sh_now[s_q.rx_idx] = rxd;
  end
  assign rx_new = rx_decode(rx_sh_now, nbits, parity_enable_bit, parity_odd);
  assign frame_done = (s_q.rx_state == spri_pkg::SPRI_RX_BUSY) && tick
    && (s_q.rx_sub == {1'b0, div_last[3:1]})
    && (s_q.rx_idx == nbits + 4'h1 + 4'(parity_enable_bit));
  assign start_seen = (s_q.rx_state == spri_pkg::SPRI_RX_IDLE) && tick && !rxd
    && s_q.receiver_enable;
  assign rx_push = s_q.rx_pend;

  spri_fifo #(
    .WIDTH(11),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(!s_q.receiver_enable),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(s_q.rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_data(rx_head)
  );

  // oversampling divisor select
  always_comb
  begin
    if (sync_mode_select)
      div_last = `SPRI_OVERSAMPLE_SYNC;
    else if (s_q.double_speed)
      div_last = `SPRI_OVERSAMPLE_DOUBLE;
    else
      div_last = `SPRI_OVERSAMPLE_NORMAL;
  end

  // next state of the whole block
  always_comb
  begin
    logic [7:0] rd_val;
    rd_val = 8'h00;
    s_d = s_q;
    // shared location read tracking
    s_d.shared_rd = rd_shared;
    // register reads
    unique case (io_addr)
      `SPRI_ADDR_DATA: rd_val = rx_head[7:0];
      `SPRI_ADDR_STATUS_A: rd_val = {rx_valid, s_q.tx_complete_flag, !s_q.tx_full,
        rx_valid && rx_head[`SPRI_WORD_FE], s_q.overrun_flag,
        rx_valid && rx_head[`SPRI_WORD_PE], s_q.double_speed,
        s_q.multiprocessor_filter};
      `SPRI_ADDR_CONTROL_B: rd_val = {s_q.rx_complete_irq_enable, s_q.tx_complete_irq_enable,
        s_q.tx_empty_irq_enable, s_q.receiver_enable, s_q.transmitter_enable,
        s_q.char_size_msb, rx_head[8], s_q.tx_ninth_bit};
      `SPRI_ADDR_BAUD_LOW: rd_val = s_q.baud_divisor[7:0];
      `SPRI_ADDR_SHARED: rd_val = s_q.shared_rd ? {1'b1, s_q.control_c}
        : {4'h0, s_q.baud_divisor[11:8]};
      default: rd_val = 8'h00;
    endcase
    if (io_rd)
      s_d.rdata = rd_val;
    // register writes
    if (io_wr)
    begin
      unique case (io_addr)
        `SPRI_ADDR_STATUS_A:
        begin
          if (io_wdata[`SPRI_TXC_BIT])
            s_d.tx_complete_flag = 1'b0;
          s_d.double_speed = io_wdata[1];
          s_d.multiprocessor_filter = io_wdata[0];
        end
        `SPRI_ADDR_CONTROL_B:
        begin
          s_d.rx_complete_irq_enable = io_wdata[7];
          s_d.tx_complete_irq_enable = io_wdata[6];
          s_d.tx_empty_irq_enable = io_wdata[5];
          s_d.receiver_enable = io_wdata[4];
          s_d.transmitter_enable = io_wdata[3];
          s_d.char_size_msb = io_wdata[2];
          s_d.tx_ninth_bit = io_wdata[0];
        end
        `SPRI_ADDR_BAUD_LOW: s_d.baud_divisor[7:0] = io_wdata;
        default:
        begin
        end
      endcase
    end
    if (wr_shared)
    begin
      if (io_wdata[`SPRI_SEL_BIT])
        s_d.control_c = io_wdata[6:0];
      else
        s_d.baud_divisor[11:8] = io_wdata[3:0];
    end
    if (tx_complete_ack)
      s_d.tx_complete_flag = 1'b0;
    // baud prescaler
    if (io_wr && (io_addr == `SPRI_ADDR_BAUD_LOW))
      s_d.prescale = {s_q.baud_divisor[11:8], io_wdata};
    else if (tick)
      s_d.prescale = s_q.baud_divisor;
    else
      s_d.prescale = s_q.prescale - 12'h001;
    // transmit buffer fill, dropped while full
    if (wr_data && !s_q.tx_full)
    begin
      s_d.transmit_buffer = {s_q.tx_ninth_bit, io_wdata};
      s_d.tx_full = 1'b1;
    end
    // transmitter enable and pin ownership
    if (s_q.transmitter_enable)
      s_d.tx_active = 1'b1;
    else if (!s_q.tx_busy && !s_q.tx_full)
      s_d.tx_active = 1'b0;
    // transmit shifter
    if (s_q.tx_busy)
    begin
      if (tick)
      begin
        if (s_q.tx_sub == div_last)
        begin
          s_d.tx_sub = 4'h0;
          s_d.txd = s_q.tx_shift[0];
          s_d.tx_shift = {1'b1, s_q.tx_shift[12:1]};
          s_d.tx_left = s_q.tx_left - 4'h1;
          if (s_q.tx_left == 4'h0)
          begin
            s_d.tx_busy = 1'b0;
            s_d.txd = 1'b1;
            if (!s_q.tx_full)
              s_d.tx_complete_flag = 1'b1;
          end
        end
        else
          s_d.tx_sub = s_q.tx_sub + 4'h1;
      end
    end
    else if (s_q.tx_active && s_q.tx_full)
    begin
      s_d.tx_busy = 1'b1;
      s_d.tx_full = 1'b0;
      s_d.tx_sub = div_last;
      s_d.tx_shift = tx_frame(s_q.transmit_buffer, nbits, parity_enable_bit, parity_odd);
      s_d.tx_left = nbits + 4'h2 + 4'(parity_enable_bit) + 4'(stop_two);
    end
    // receiver sequencing
    unique case (s_q.rx_state)
      spri_pkg::SPRI_RX_IDLE:
      begin
        if (start_seen)
        begin
          if (s_q.rx_pend)
            s_d.overrun_flag = 1'b1;
          else
          begin
            s_d.rx_state = spri_pkg::SPRI_RX_BUSY;
            s_d.rx_sub = 4'h0;
            s_d.rx_idx = 4'h0;
          end
        end
      end
      spri_pkg::SPRI_RX_BUSY:
      begin
        if (tick)
        begin
          s_d.rx_sub = (s_q.rx_sub == div_last) ? 4'h0 : s_q.rx_sub + 4'h1;
          if (s_q.rx_sub == div_last)
            s_d.rx_idx = s_q.rx_idx + 4'h1;
          if (s_q.rx_sub == {1'b0, div_last[3:1]})
          begin
            s_d.rx_shift[s_q.rx_idx] = rxd;
            if (s_q.rx_idx == 4'h0 && rxd)
              s_d.rx_state = spri_pkg::SPRI_RX_IDLE;
          end
        end
        if (frame_done)
          s_d.rx_state = spri_pkg::SPRI_RX_IDLE;
      end
    endcase
    // hand a finished frame to the fifo
    if (rx_push && rx_ready)
      s_d.rx_pend = 1'b0;
    if (frame_done)
    begin
      // frame type is the ninth bit in 9-bit frames, else the stop bit
      if (!s_q.multiprocessor_filter
          || ((nbits == 4'h9) ? rx_new[8] : !rx_new[`SPRI_WORD_FE]))
      begin
        s_d.rx_pend = 1'b1;
        s_d.rx_word = rx_new;
      end
    end
    // overrun clears when the data register is read, unless a new overrun is flagged in that same cycle
    if (rd_data && !(start_seen && s_q.rx_pend))
      s_d.overrun_flag = 1'b0;
    if (!s_q.receiver_enable)
    begin
      s_d.rx_state = spri_pkg::SPRI_RX_IDLE;
      s_d.rx_pend = 1'b0;
      s_d.overrun_flag = 1'b0;
    end
    // interrupt requests
    s_d.irq_rx = s_q.rx_complete_irq_enable && global_irq_enable && rx_valid;
    s_d.irq_tx = s_q.tx_complete_irq_enable && global_irq_enable && s_q.tx_complete_flag;
    s_d.irq_empty = s_q.tx_empty_irq_enable && global_irq_enable && !s_q.tx_full;
  end

  // state registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.control_c <= 7'(`SPRI_RESET_CONTROL_C);
      s_q.txd <= 1'b1;
      s_q.rx_shift <= 12'hfff;
    end
    else
      s_q <= s_d;
  end

  // outputs from flops
  assign io_rdata = s_q.rdata;
  assign irq_rx_complete = s_q.irq_rx;
  assign irq_tx_complete = s_q.irq_tx;
  assign irq_tx_empty = s_q.irq_empty;
  assign rx_pin_owned = s_q.receiver_enable;
  assign txd = s_q.txd;
  assign txd_oe = s_q.tx_active;

  // ****************************************
  // assertions
  // ****************************************
  sequence seq_two_reads;
    rd_shared ##1 rd_shared;
  endsequence
  sequence seq_lone_read;
    !rd_shared ##1 rd_shared;
  endsequence

  a_shared_ctrl_c: assert property (@(posedge clk) disable iff (!resetn)
    seq_two_reads |=> (io_rdata[7] == 1'b1) && (io_rdata[6:0] == $past(s_q.control_c)))
    else $error("second shared read did not return control C");
  a_shared_baud_hi: assert property (@(posedge clk) disable iff (!resetn)
    seq_lone_read |=> io_rdata == {4'h0, $past(s_q.baud_divisor[11:8])})
    else $error("single shared read did not return baud high");
  a_tx_write_drop: assert property (@(posedge clk) disable iff (!resetn)
    wr_data && s_q.tx_full |=> $stable(s_q.transmit_buffer))
    else $error("write while buffer full changed pending data");
  a_rx_flush_empty: assert property (@(posedge clk) disable iff (!resetn)
    !s_q.receiver_enable ##1 !s_q.receiver_enable |-> !rx_valid && !s_q.overrun_flag)
    else $error("receive fifo not flushed while receiver disabled");
  a_tx_load_shift: assert property (@(posedge clk) disable iff (!resetn)
    s_q.tx_active && !s_q.tx_busy && s_q.tx_full |=> s_q.tx_busy && !s_q.tx_full)
    else $error("buffered data not moved into shifter");
  a_tx_disable_wait: assert property (@(posedge clk) disable iff (!resetn)
    s_q.tx_active && (s_q.tx_busy || s_q.tx_full) |=> s_q.tx_active)
    else $error("transmitter released pin with data pending");
  a_irq_rx_gate: assert property (@(posedge clk) disable iff (!resetn)
    ##1 irq_rx_complete == $past(s_q.rx_complete_irq_enable && global_irq_enable && rx_valid))
    else $error("receive interrupt not gated by its three conditions");
  a_txc_set_done: assert property (@(posedge clk) disable iff (!resetn)
    s_q.tx_busy ##1 !s_q.tx_busy && !s_q.tx_full |-> s_q.tx_complete_flag)
    else $error("transmit complete not set after frame left");
  a_overrun_set: assert property (@(posedge clk) disable iff (!resetn)
    start_seen && s_q.rx_pend |=> s_q.overrun_flag)
    else $error("overrun not flagged on start while full");
endmodule
`default_nettype wire

// [verif/spri_remote.sv]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// remote serial node on the line pair
// ****************************************
module spri_remote (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  int bit_clks = 16;

  // line idles high between frames
  initial rxd = 1'b1;

  // sends n bits lsb first, one bit time each
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= bits[i];
      repeat (bit_clks) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask

  // waits a bounded time for a start bit, then samples n bits mid-bit
  task automatic recv(input int n, output logic [15:0] bits, output logic seen);
    int t;
    bits = '0;
    seen = 1'b0;
    for (t = 0; t < 600 && txd !== 1'b0; t++)
      @(negedge clk);
    if (txd === 1'b0)
    begin
      seen = 1'b1;
      repeat (bit_clks / 2) @(negedge clk);
      for (int i = 0; i < n; i++)
      begin
        repeat (bit_clks) @(negedge clk);
        bits[i] = txd;
      end
    end
  endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "spri_defines.svh"

// ****************************************
// compare helper
// ****************************************
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module testbench;
  localparam logic [2:0] AD = `SPRI_ADDR_DATA;
  localparam logic [2:0] AS = `SPRI_ADDR_STATUS_A;
  localparam logic [2:0] AB = `SPRI_ADDR_CONTROL_B;
  localparam logic [2:0] AL = `SPRI_ADDR_BAUD_LOW;
  localparam logic [2:0] AC = `SPRI_ADDR_SHARED;
  logic clk;
  logic resetn;
  logic [2:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic global_irq_enable;
  logic tx_complete_ack;
  logic irq_rx_complete;
  logic irq_tx_complete;
  logic irq_tx_empty;
  logic rxd;
  logic rx_pin_owned;
  logic txd;
  logic txd_oe;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] d;
  logic [7:0] d1;
  logic [15:0] bits;
  logic seen;
  logic [7:0] ctc [3] = '{8'h86, 8'h86, 8'hc6};
  logic [7:0] sta [3] = '{8'h00, 8'h02, 8'h02};
  logic [7:0] dat [3] = '{8'h5a, 8'ha5, 8'h3c};
  int bt [3] = '{16, 8, 2};

  // device and remote node
  spri_top #(.RX_DEPTH(2)) u_dut (.clk(clk), .resetn(resetn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .tx_complete_ack(tx_complete_ack),
    .irq_rx_complete(irq_rx_complete), .irq_tx_complete(irq_tx_complete),
    .irq_tx_empty(irq_tx_empty), .rxd(rxd), .rx_pin_owned(rx_pin_owned),
    .txd(txd), .txd_oe(txd_oe));
  spri_remote u_remote (.clk(clk), .txd(txd), .rxd(rxd));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // register port tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    v = io_rdata;
  endtask

  // two reads of the shared place on consecutive cycles, never split
  task automatic rd_pair(output logic [7:0] v0, output logic [7:0] v1);
    @(posedge clk);
    io_addr <= AC;
    io_rd <= 1'b1;
    @(posedge clk);
    #1;
    v0 = io_rdata;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    v1 = io_rdata;
  endtask

  // remote frame then settle time
  task automatic rxf(input logic [15:0] b, input int n);
    u_remote.send(b, n);
    cyc(24);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(AS, d);
    `CHK(d, 8'h20);
    rd(AB, d);
    `CHK(d, 8'h00);
    `CHK({txd, txd_oe, rx_pin_owned}, 3'b100);
    rd_pair(d, d1);
    `CHK({d, d1}, 16'h0080);
  endtask

  task automatic t_shared();
    wr(AC, 8'h05);
    wr(AC, 8'h86);
    rd(AC, d);
    `CHK(d, 8'h05);
    rd(AC, d);
    `CHK(d, 8'h05);
    rd_pair(d, d1);
    `CHK({d, d1}, 16'h0586);
    wr(AC, 8'h00);
    wr(AL, 8'h00);
  endtask

  // normal, double speed and synchronous bit times
  task automatic t_modes();
    for (int i = 0; i < 3; i++)
    begin
      wr(AS, sta[i]);
      wr(AC, ctc[i]);
      u_remote.bit_clks = bt[i];
      wr(AB, 8'h08);
      wr(AD, dat[i]);
      u_remote.recv(9, bits, seen);
      `CHK(bits[8:0], {1'b1, dat[i]});
      cyc(2 * bt[i] + 4);
      rd(AS, d);
      `CHK(d[6], 1'b1);
      wr(AS, 8'h40);
      rd(AS, d);
      `CHK(d[6], 1'b0);
    end
    wr(AS, 8'h00);
    wr(AC, 8'h86);
    u_remote.bit_clks = 16;
  endtask

  task automatic t_tx_flow();
    wr(AD, 8'h11);
    // remote must be watching before the start bit begins
    fork
      u_remote.recv(9, bits, seen);
      begin
        wr(AD, 8'h22);
        rd(AS, d);
        `CHK(d[5], 1'b0);
        wr(AD, 8'h33);
        wr(AB, 8'h00);
        `CHK(txd_oe, 1'b1);
      end
    join
    `CHK(bits[8:0], 9'h111);
    u_remote.recv(9, bits, seen);
    `CHK(bits[8:0], 9'h122);
    u_remote.recv(9, bits, seen);
    `CHK(seen, 1'b0);
    `CHK(txd_oe, 1'b0);
    wr(AB, 8'h60);
    global_irq_enable <= 1'b1;
    cyc(3);
    `CHK({irq_tx_complete, irq_tx_empty}, 2'b11);
    global_irq_enable <= 1'b0;
    cyc(3);
    `CHK({irq_tx_complete, irq_tx_empty}, 2'b00);
    @(posedge clk);
    tx_complete_ack <= 1'b1;
    @(posedge clk);
    tx_complete_ack <= 1'b0;
    rd(AS, d);
    `CHK(d[6], 1'b0);
  endtask

  task automatic t_tx_size();
    wr(AC, 8'h80);
    wr(AB, 8'h08);
    wr(AD, 8'hc1);
    u_remote.recv(6, bits, seen);
    `CHK(bits[5:0], 6'h21);
    wr(AC, 8'h86);
    wr(AB, 8'h0d);
    wr(AD, 8'h55);
    u_remote.recv(10, bits, seen);
    `CHK(bits[9:0], 10'h355);
    cyc(40);
  endtask

  task automatic t_rx_fifo();
    wr(AB, 8'h90);
    cyc(2);
    `CHK(rx_pin_owned, 1'b1);
    rxf({6'h3f, 1'b1, 8'h3c, 1'b0}, 10);
    global_irq_enable <= 1'b1;
    rd(AS, d);
    `CHK(d[7], 1'b1);
    cyc(2);
    `CHK(irq_rx_complete, 1'b1);
    rd(AD, d);
    `CHK(d, 8'h3c);
    rd(AD, d);
    rd(AS, d);
    `CHK(d[7], 1'b0);
    rxf({6'h3f, 1'b1, 8'h01, 1'b0}, 10);
    rxf({6'h3f, 1'b0, 8'h02, 1'b0}, 10);
    rxf({6'h3f, 1'b1, 8'h03, 1'b0}, 10);
    rxf({6'h3f, 1'b1, 8'h04, 1'b0}, 10);
    rd(AS, d);
    `CHK(d & 8'h98, 8'h88);
    rd(AD, d);
    `CHK(d, 8'h01);
    rd(AS, d);
    `CHK(d & 8'h18, 8'h10);
    rd(AD, d);
    `CHK(d, 8'h02);
    rd(AD, d);
    `CHK(d, 8'h03);
    rd(AS, d);
    `CHK(d[7], 1'b0);
    global_irq_enable <= 1'b0;
  endtask

  task automatic t_rx_misc();
    wr(AC, 8'ha6);
    rxf({5'h1f, 1'b1, 1'b0, 8'h07, 1'b0}, 11);
    rd(AS, d);
    `CHK(d[2], 1'b1);
    rd(AD, d);
    wr(AC, 8'h86);
    wr(AS, 8'h01);
    rxf({6'h3f, 1'b0, 8'h44, 1'b0}, 10);
    rxf({6'h3f, 1'b1, 8'h45, 1'b0}, 10);
    rd(AD, d);
    `CHK(d, 8'h45);
    wr(AS, 8'h00);
    wr(AB, 8'h14);
    rxf({5'h1f, 1'b1, 1'b1, 8'h66, 1'b0}, 11);
    rd(AB, d);
    `CHK(d[1], 1'b1);
    rd(AD, d);
    `CHK(d, 8'h66);
    wr(AB, 8'h10);
    wr(AC, 8'h80);
    rxf({9'h1ff, 1'b1, 5'h15, 1'b0}, 7);
    rd(AD, d);
    `CHK(d, 8'h15);
    rxf({9'h1ff, 1'b0, 5'h0a, 1'b0}, 7);
    wr(AB, 8'h00);
    cyc(2);
    rd(AS, d);
    `CHK({d & 8'h9c, rx_pin_owned}, 9'h000);
  endtask

  // ****************************************
  // verdict and watchdog
  // ****************************************
  task automatic test_done();
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    test_done();
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    global_irq_enable = 1'b0;
    tx_complete_ack = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_shared();
    t_modes();
    t_tx_flow();
    t_tx_size();
    t_rx_fifo();
    t_rx_misc();
    test_done();
  end
endmodule

`default_nettype wire
